// ==== rtl/acd_defines.svh ====
`ifndef ACD_DEFINES_SVH
`define ACD_DEFINES_SVH

// Register index of the change reference angle.
`define ACD_REF_ADDR   5'h0A
// Reset value of the change reference angle.
`define ACD_REF_RST    8'h00
// Reset value of the register read data.
`define ACD_RDATA_RST  8'h00
// Reset value of the output angle.
`define ACD_ANGLE_RST  16'h0000
// Threshold code meaning zero degrees.
`define ACD_THR_ZERO   8'h00
// Threshold code meaning exactly 180 degrees.
`define ACD_THR_HALF   8'h80
// Angular distance of exactly 180 degrees.
`define ACD_DIST_HALF  9'h080
// Full turn in reference steps.
`define ACD_DIST_TURN  9'h100

`endif

// ==== rtl/acd_pkg.sv ====
// Shared types of the angle change detector.
package acd_pkg;

   // One 8-bit angle, reference or threshold code.
   typedef logic [7:0] acd_byte_t;

   // Angular distance, 0 to 128 steps of 360/256 degrees.
   typedef logic [8:0] acd_dist_t;

   // Register index.
   typedef logic [4:0] acd_addr_t;

   // Sequencing states of the detector.
   typedef enum logic [1:0]
   {
      ACD_ST_WAIT = 2'b00,
      ACD_ST_EVAL = 2'b01
   } acd_state_e;

endpackage

// ==== rtl/acd_distance.sv ====
`timescale 1ns/1ns
`include "acd_defines.svh"

// Compares one sampled angle with the reference and the threshold.
module acd_distance
(
   input  wire acd_pkg::acd_byte_t sample_i,
   input  wire acd_pkg::acd_byte_t reference_i,
   input  wire acd_pkg::acd_byte_t threshold_i,
   output acd_pkg::acd_dist_t      distance_o,
   output logic                     crossing_o
);
   import acd_pkg::*;

   acd_byte_t diff;  // Difference modulo one full turn.

   ////////////////////////////////////////////////////////////////////////
   // The shorter way round is taken, so the distance never passes 180.
   always_comb
   begin
      diff = sample_i - reference_i;
      if (diff[7])
      begin
         distance_o = `ACD_DIST_TURN - {1'b0, diff};
      end
      else
      begin
         distance_o = {1'b0, diff};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // The threshold is a relative angle in the same steps as the angle.
   always_comb
   begin
      if (threshold_i == `ACD_THR_ZERO)
      begin
         crossing_o = 1'b1;
      end
      else if (threshold_i == `ACD_THR_HALF)
      begin
         crossing_o = (distance_o == `ACD_DIST_HALF);
      end
      else if (threshold_i > `ACD_THR_HALF)
      begin
         crossing_o = 1'b0;
      end
      else
      begin
         crossing_o = (distance_o > {1'b0, threshold_i});
      end
   end

endmodule

// ==== rtl/acd_core.sv ====
// Functional notes
// - Threshold counts steps of 360/256 degrees.
// - Code 128 flags only at 180; above never.
// - Reference angle is read/write register 10.
// - Reference is absolute, same step size.
// - Beyond threshold, flag sets every period with valid data.
// - Threshold zero flags after every period with valid data.
// - Angle read, NVM, clear-status commands clear flag.
// - ID read and register accesses keep flag.
// - Cycling mode updates angle at period end.
`timescale 1ns/1ns
`include "acd_defines.svh"

// Wakeup-on-change logic: stores the reference, holds the output angle
// and raises the new data flag when the angle leaves the threshold.
module acd_core
#(
   parameter int ANGLE_W = 16  // Width of the measured angle.
)
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 nrst_i,
   input  wire logic [ANGLE_W-1:0]   meas_angle_i,
   input  wire logic                 data_valid_i,
   input  wire logic                 active_end_i,
   input  wire logic                 auto_power_cycling_i,
   input  wire acd_pkg::acd_byte_t   change_threshold_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   input  wire acd_pkg::acd_addr_t   reg_addr_i,
   input  wire acd_pkg::acd_byte_t   reg_wdata_i,
   input  wire logic                 cmd_read_angle_i,
   input  wire logic                 cmd_store_nvm_i,
   input  wire logic                 cmd_restore_nvm_i,
   input  wire logic                 cmd_clear_status_i,
   input  wire logic                 cmd_read_id_i,
   output logic [ANGLE_W-1:0]        angle_o,
   output logic                      new_data_flag_o,
   output acd_pkg::acd_byte_t        reg_rdata_o
);
   import acd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   acd_state_e         state_q;      // Sequencing state.
   acd_state_e         state_d;      // Next sequencing state.
   logic [ANGLE_W-1:0] sample_q;     // Angle caught at the period end.
   logic [ANGLE_W-1:0] sample_d;     // Next caught angle.
   logic [ANGLE_W-1:0] angle_q;      // Angle shown to the host.
   logic [ANGLE_W-1:0] angle_d;      // Next shown angle.
   logic               flag_q;       // New data flag.
   logic               flag_d;       // Next new data flag.
   acd_byte_t          ref_q;        // Change reference angle.
   acd_byte_t          ref_d;        // Next reference angle.
   acd_byte_t          rdata_q;      // Register read data.
   acd_byte_t          rdata_d;      // Next register read data.
   acd_dist_t          distance;     // Distance of sample to reference.
   logic               crossing;     // Sample lies beyond the threshold.
   logic               clear_cmd;    // A command that clears the flag.
   logic               flag_set;     // The flag is raised this cycle.

   // Tells whether an index selects the change reference register.
   function automatic logic is_ref(input acd_addr_t addr);
      is_ref = (addr == `ACD_REF_ADDR);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Comparison of the caught sample against the reference.

   // Only the upper byte of the angle meets the 8-bit reference.
   acd_distance u_distance
   (
      .sample_i    (sample_q[ANGLE_W-1 -: 8]),
      .reference_i (ref_q),
      .threshold_i (change_threshold_i),
      .distance_o  (distance),
      .crossing_o  (crossing)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next values of all state.
   always_comb
   begin
      state_d  = state_q;
      sample_d = sample_q;
      angle_d  = angle_q;
      flag_d   = flag_q;
      ref_d    = ref_q;
      rdata_d  = rdata_q;
      // ID reads and register accesses are not in this list.
      clear_cmd = cmd_read_angle_i | cmd_store_nvm_i |
                  cmd_restore_nvm_i | cmd_clear_status_i;
      flag_set  = (state_q == ACD_ST_EVAL) && crossing;

      // A period that ends without valid data leaves everything alone.
      case (state_q)
         ACD_ST_WAIT:
         begin
            if (active_end_i && data_valid_i)
            begin
               sample_d = meas_angle_i;
               state_d  = ACD_ST_EVAL;
            end
         end
         ACD_ST_EVAL:
         begin
            angle_d = sample_q;
            state_d = ACD_ST_WAIT;
         end
         default:
         begin
            state_d = ACD_ST_WAIT;
         end
      endcase

      // Outside cycling mode the angle follows every valid conversion.
      if (!auto_power_cycling_i && data_valid_i)
      begin
         angle_d = meas_angle_i;
      end

      // A new event wins over a clear in the same cycle.
      if (flag_set)
      begin
         flag_d = 1'b1;
      end
      else if (clear_cmd)
      begin
         flag_d = 1'b0;
      end

      // Register write of the reference.
      if (reg_wr_i && is_ref(reg_addr_i))
      begin
         ref_d = reg_wdata_i;
      end

      // Register read; unknown indices read as zero.
      if (reg_rd_i)
      begin
         rdata_d = is_ref(reg_addr_i) ? ref_q : `ACD_RDATA_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers.
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         state_q  <= ACD_ST_WAIT;
         sample_q <= `ACD_ANGLE_RST;
         angle_q  <= `ACD_ANGLE_RST;
         flag_q   <= 1'b0;
         ref_q    <= `ACD_REF_RST;
         rdata_q  <= `ACD_RDATA_RST;
      end
      else
      begin
         state_q  <= state_d;
         sample_q <= sample_d;
         angle_q  <= angle_d;
         flag_q   <= flag_d;
         ref_q    <= ref_d;
         rdata_q  <= rdata_d;
      end
   end

   // Outputs come straight from the registers.
   assign angle_o         = angle_q;
   assign new_data_flag_o = flag_q;
   assign reg_rdata_o     = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the register.

   ref_write_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      reg_wr_i && is_ref(reg_addr_i)
      |=> ref_q == $past(reg_wdata_i))
      else $error("Reference write not stored.");

   ref_read_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      reg_rd_i && is_ref(reg_addr_i)
      |=> reg_rdata_o == $past(ref_q))
      else $error("Reference read returns wrong value.");

   ////////////////////////////////////////////////////////////////////////
   // Checks on the flag.

   zero_thr_flag_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == ACD_ST_EVAL && change_threshold_i == `ACD_THR_ZERO
      |=> new_data_flag_o)
      else $error("Zero threshold did not raise flag.");

   big_thr_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      change_threshold_i > `ACD_THR_HALF && clear_cmd
      |=> !new_data_flag_o)
      else $error("Flag raised with threshold above 180.");

   half_thr_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == ACD_ST_EVAL && change_threshold_i == `ACD_THR_HALF
      |=> new_data_flag_o == ($past(distance) == `ACD_DIST_HALF
          || $past(flag_q) && !$past(clear_cmd)))
      else $error("Half-turn threshold misjudged.");

   in_window_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      state_q == ACD_ST_EVAL
      && change_threshold_i != `ACD_THR_ZERO
      && change_threshold_i < `ACD_THR_HALF
      && distance <= {1'b0, change_threshold_i}
      |=> new_data_flag_o == ($past(flag_q) && !$past(clear_cmd)))
      else $error("Flag raised inside the threshold.");

   cross_set_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      active_end_i && data_valid_i && state_q == ACD_ST_WAIT
      ##1 crossing |=> new_data_flag_o)
      else $error("Crossing did not raise flag.");

   clear_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      clear_cmd && state_q == ACD_ST_WAIT |=> !new_data_flag_o)
      else $error("Clear command did not clear flag.");

   hold_flag_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (reg_wr_i || reg_rd_i || cmd_read_id_i) && !clear_cmd
      && state_q == ACD_ST_WAIT |=> $stable(new_data_flag_o))
      else $error("Flag changed by an access that keeps it.");

   ////////////////////////////////////////////////////////////////////////
   // Checks on the angle.

   angle_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      auto_power_cycling_i && state_q == ACD_ST_WAIT
      |=> $stable(angle_o))
      else $error("Angle changed during the active period.");

   angle_upd_a: assert property (
      @(posedge sys_clk_i) disable iff (!nrst_i)
      auto_power_cycling_i && active_end_i && data_valid_i
      && state_q == ACD_ST_WAIT
      ##1 auto_power_cycling_i |=> angle_o == $past(meas_angle_i, 2))
      else $error("Angle not updated at period end.");

endmodule

// ==== test/acd_host_model.sv ====
`timescale 1ns/1ns
`include "acd_defines.svh"

// Host side of the serial port, reduced to decoded strobes.
// Strobes rise after a falling edge and stay up for one rising edge.
module acd_host_model
(
   input  wire logic               clk_i,
   input  wire acd_pkg::acd_byte_t rdata_i,
   output logic                    wr_o,
   output logic                    rd_o,
   output acd_pkg::acd_addr_t      addr_o,
   output acd_pkg::acd_byte_t      wdata_o,
   output logic [4:0]              cmd_o
);
   import acd_pkg::*;

   // Idle bus at time zero.
   initial
   begin
      {wr_o, rd_o, cmd_o, addr_o, wdata_o} = '0;
   end

   // One register write; released lines show inverted values.
   task automatic wr(input acd_addr_t a, input acd_byte_t d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask

   // One register read; data is taken after the sampling edge.
   task automatic rd(input acd_addr_t a, output acd_byte_t d);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask

   // Command pulse: 0 angle, 1 store, 2 restore, 3 clear, 4 id.
   task automatic cmd(input int k);
      @(negedge clk_i);
      cmd_o = 5'h01 << k;
      @(negedge clk_i);
      cmd_o = 5'h00;
   endtask

   // Moves the reference onto the angle just seen.
   task automatic rebase(input acd_byte_t a);
      wr(`ACD_REF_ADDR, a);
   endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ns
`include "acd_defines.svh"

module tb;
   import acd_pkg::*;

   logic        clk;
   logic        nrst;
   logic        dv;
   logic        ae;
   logic        apc;
   logic [15:0] meas;
   acd_byte_t   change_threshold;
   logic        wr;
   logic        rd;
   acd_addr_t   addr;
   acd_byte_t   wdata;
   logic [4:0]  cmd;
   logic [15:0] angle;
   logic        flag;
   acd_byte_t   rdata;
   acd_byte_t   rv;
   int          bad_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   // Rows of {reference, angle, threshold, expected flag}.
   logic [31:0] tbl [12] = '{32'h00000001, 32'h000A0A00,
      32'h000B0A01, 32'h05FB0A00, 32'h05FA0A01, 32'h007F7F00,
      32'h00807F01, 32'h007F8000, 32'hC0408001, 32'h00808100,
      32'h0080FF00, 32'h1090FF00};

   acd_core acd_core_inst (.sys_clk_i(clk), .nrst_i(nrst),
      .meas_angle_i(meas), .data_valid_i(dv), .active_end_i(ae),
      .auto_power_cycling_i(apc), .change_threshold_i(change_threshold),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .cmd_read_angle_i(cmd[0]),
      .cmd_store_nvm_i(cmd[1]), .cmd_restore_nvm_i(cmd[2]),
      .cmd_clear_status_i(cmd[3]), .cmd_read_id_i(cmd[4]),
      .angle_o(angle), .new_data_flag_o(flag), .reg_rdata_o(rdata));

   acd_host_model acd_host_model_inst (.clk_i(clk), .rdata_i(rdata),
      .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
      .cmd_o(cmd));

   ////////////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cuts a hang short after far more cycles than the tests need.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         bad_count++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counts one comparison and reports a mismatch.
   task automatic chk(input logic [15:0] got, exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t %s", $time, m);
      end
   endtask

   // One active period ending with a sample of angle a, settled only if dv is set.
   task automatic period(input acd_byte_t a);
      @(negedge clk);
      meas = {a, 8'h3C};
      ae = 1'b1;
      @(negedge clk);
      ae = 1'b0;
      @(negedge clk);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence of tests.
   initial
   begin
      {nrst, dv, ae, meas, change_threshold} = '0;
      apc = 1'b1;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      dv = 1'b1;
      chk(angle, 16'h0000, "reset angle");
      chk(flag, 1'b0, "reset flag");
      acd_host_model_inst.rd(`ACD_REF_ADDR, rv);
      chk(rv, 8'h00, "reset reference");
      acd_host_model_inst.wr(`ACD_REF_ADDR, 8'hA5);
      acd_host_model_inst.wr(5'h0B, 8'h3C);
      acd_host_model_inst.rd(`ACD_REF_ADDR, rv);
      chk(rv, 8'hA5, "reference readback");
      acd_host_model_inst.rd(5'h0B, rv);
      chk(rv, 8'h00, "unmapped read");
      $display("test registers done");
      foreach (tbl[i])
      begin
         acd_host_model_inst.wr(`ACD_REF_ADDR, tbl[i][31:24]);
         acd_host_model_inst.cmd(3);
         change_threshold = tbl[i][15:8];
         period(tbl[i][23:16]);
         chk(flag, tbl[i][0], "threshold row");
         chk(angle, {tbl[i][23:16], 8'h3C}, "angle update");
      end
      $display("test thresholds done");
      change_threshold = 8'h0A;
      acd_host_model_inst.wr(`ACD_REF_ADDR, 8'h00);
      period(8'h40);
      acd_host_model_inst.cmd(0);
      chk(flag, 1'b0, "flag after angle read");
      period(8'h40);
      chk(flag, 1'b1, "flag again beyond");
      acd_host_model_inst.cmd(4);
      acd_host_model_inst.rd(`ACD_REF_ADDR, rv);
      acd_host_model_inst.rebase(8'h40);
      chk(flag, 1'b1, "flag kept");
      acd_host_model_inst.cmd(3);
      period(8'h45);
      chk(flag, 1'b0, "quiet after rebase");
      $display("test repeat done");
      change_threshold = 8'h00;
      for (int k = 0; k < 4; k++)
      begin
         period(8'h20);
         chk(flag, 1'b1, "flag set");
         acd_host_model_inst.cmd(k);
         chk(flag, 1'b0, "flag cleared");
      end
      $display("test clears done");
      meas = 16'h7777;
      repeat (3) @(negedge clk);
      chk(angle, 16'h203C, "angle held");
      dv = 1'b0;
      period(8'h77);
      chk(angle, 16'h203C, "unsettled sample");
      chk(flag, 1'b0, "no flag unsettled");
      dv = 1'b1;
      period(8'h77);
      chk(angle, 16'h773C, "angle at end");
      apc = 1'b0;
      meas = 16'h1234;
      repeat (2) @(negedge clk);
      chk(angle, 16'h1234, "direct mode");
      $display("test angle done");
      // Reset in mid-run clears the flag and the reference.
      nrst = 1'b0;
      @(negedge clk);
      nrst = 1'b1;
      chk(flag, 1'b0, "flag after reset");
      acd_host_model_inst.rd(`ACD_REF_ADDR, rv);
      chk(rv, 8'h00, "reference after reset");
      $display("test reset done");
      close_out();
   end
endmodule
